// file: rtl/iob_internal_osc.sv
// internal oscillator block: sources, postscaler, switch and status
`timescale 1ns/1ps
// Overview of operation
// - internal config selects block after every reset
// - software switches to internal via select field
// - clock pins become io, output optional
// - 16 MHz derived from 500 kHz by loop
// - uncalibrated 31 kHz third internal source
// - trim register adjusts high and medium rates
// - high rate through postscaler, 4-bit select
// - nine medium-derived rates from same field
// - high enabled: hf select and internal/1x
// - medium enabled: any non-low select and internal/1x
// - startup delay before switching to high source
// - hf ready while high oscillator runs
// - hf locked within 2 percent
// - hf stable within 0.5 percent
// - mf ready while medium oscillator runs
// - two oscillators plus loop, three sources
module iob_internal_osc (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // configuration word
  input  wire logic [2:0] osc_config_select,
  input  wire logic       clk_pin_output_enable,
  // control register fields
  input  wire logic [1:0] sys_clk_source_select,
  input  wire logic [3:0] internal_freq_select,
  input  wire logic [5:0] osc_trim_reg,
  // clock pins as general io
  input  wire logic       clock_input_pin,
  input  wire logic       clock_output_pin_gpio_out,
  input  wire logic       clock_output_pin_gpio_oe,
  output logic            clock_input_pin_gpio_in,
  output logic            clock_output_pin,
  output logic            clock_output_pin_oe,
  // system clock enable and selection
  output logic            sys_clk_en,
  output logic            internal_osc_mode,
  output logic [1:0]      active_source,
  // status register bits
  output logic            hf_ready_flag,
  output logic            hf_locked_flag,
  output logic            hf_stable_flag,
  output logic            mf_ready_flag,
  output logic            lf_tick
);

  localparam int CNT_W_L = iob_pkg::CNT_W;
  // accumulator steps: a carry out of 24 bits is one source tick,
  // so the step is the source rate as a fraction of clk
  localparam logic [23:0] MF_STEP =
    24'((64'(iob_pkg::MF_HZ) << 24) / iob_pkg::CLK_HZ);
  localparam logic [23:0] HF_STEP =
    24'(iob_pkg::PLL_MULT * int'(MF_STEP));
  localparam logic [23:0] LF_STEP =
    24'((64'(iob_pkg::LF_HZ) << 24) / iob_pkg::CLK_HZ);

  logic                      rst_s1;
  logic                      rst_n;
  // trim sign-extended to the full sum width, so negative trim
  // never wraps into the carry
  logic [24:0]               trim_ext;
  logic                      post_wrap;
  logic [2:0]                pin_sync;
  logic                      sel_internal;
  logic                      hf_req;
  logic                      mf_req;
  logic                      hf_en;
  logic                      mf_en;
  logic [CNT_W_L-1:0]        hf_cnt;
  logic [CNT_W_L-1:0]        mf_cnt;
  logic [23:0]               mf_acc;
  logic [23:0]               hf_acc;
  logic [23:0]               lf_acc;
  logic                      mf_tick;
  logic                      hf_tick;
  logic [8:0]                post_cnt;
  logic                      post_tick;
  logic                      tgt_tick;
  iob_pkg::iob_src_t         cur_src;
  iob_pkg::iob_src_t         tgt_src;
  iob_pkg::iob_src_t         next_src;
  iob_pkg::iob_sw_t          sw_state;
  logic [1:0]                sync_cnt;
  logic [3:0]                cur_div;

  assign trim_ext = {{19{osc_trim_reg[5]}}, osc_trim_reg};

  // per-select postscale length in source ticks, log2
  function automatic logic [3:0] div_log2(input logic [3:0] sel);
    if (sel >= iob_pkg::FREQ_SEL_HF_MIN)
      div_log2 = 4'hF - sel;
    else if (sel >= iob_pkg::FREQ_SEL_MF_MIN)
      div_log2 = iob_pkg::FREQ_SEL_MF_MAX - sel;
    else
      div_log2 = 4'h0;
  endfunction : div_log2

  function automatic iob_pkg::iob_src_t src_of(input logic [3:0] sel);
    if (sel == iob_pkg::FREQ_SEL_LF)
      src_of = iob_pkg::IOB_SRC_LF;
    else if (sel >= iob_pkg::FREQ_SEL_HF_MIN)
      src_of = iob_pkg::IOB_SRC_HF;
    else
      src_of = iob_pkg::IOB_SRC_MF;
  endfunction : src_of

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin input sync; stage 1 read only by stage 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync <= 3'h0;
      clock_input_pin_gpio_in <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], clock_input_pin};
      if (pin_sync[1] == pin_sync[2])
        clock_input_pin_gpio_in <= pin_sync[2];
    end
  end

  // config selects internal from reset on; 1x selects at run time
  assign sel_internal = (osc_config_select == iob_pkg::OSC_CFG_INTERNAL)
                        || sys_clk_source_select[1];
  assign internal_osc_mode = sel_internal;

  // the high source is built on the medium one, so both run for hf
  assign hf_req = sel_internal
                  && (src_of(internal_freq_select) == iob_pkg::IOB_SRC_HF);
  assign mf_req = sel_internal
                  && (src_of(internal_freq_select) != iob_pkg::IOB_SRC_LF);
  assign hf_en  = hf_req;
  assign mf_en  = mf_req || hf_req;

  // clock output pin: gpio unless configured as clock out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin    <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else if (sel_internal && clk_pin_output_enable) begin
      clock_output_pin    <= post_cnt[1];
      clock_output_pin_oe <= 1'b1;
    end else begin
      clock_output_pin    <= clock_output_pin_gpio_out;
      clock_output_pin_oe <= clock_output_pin_gpio_oe;
    end
  end

  // medium rate: phase accumulator, trim nudges the step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mf_acc  <= 24'h000000;
      mf_tick <= 1'b0;
    end else if (!mf_en) begin
      mf_acc  <= 24'h000000;
      mf_tick <= 1'b0;
    end else begin
      {mf_tick, mf_acc} <= {1'b0, mf_acc}
        + {1'b0, MF_STEP} + trim_ext;
    end
  end

  // high rate: loop multiplies the trimmed medium step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hf_acc  <= 24'h000000;
      hf_tick <= 1'b0;
    end else if (!hf_en || !hf_locked_flag) begin
      hf_acc  <= 24'h000000;
      hf_tick <= 1'b0;
    end else begin
      {hf_tick, hf_acc} <= {1'b0, hf_acc}
        + {1'b0, HF_STEP}
        + 25'(iob_pkg::PLL_MULT * 32'(signed'(osc_trim_reg)));
    end
  end

  // low rate runs free, untrimmed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_acc <= 24'h000000;
      lf_tick <= 1'b0;
    end else begin
      {lf_tick, lf_acc} <= {1'b0, lf_acc}
        + {1'b0, LF_STEP};
    end
  end

  // startup and settle counters, cleared when disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mf_cnt <= iob_pkg::CNT_ZERO;
    else if (!mf_en)
      mf_cnt <= iob_pkg::CNT_ZERO;
    else if (mf_cnt < CNT_W_L'(iob_pkg::START_CYC))
      mf_cnt <= mf_cnt + iob_pkg::CNT_ONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hf_cnt <= iob_pkg::CNT_ZERO;
    else if (!hf_en)
      hf_cnt <= iob_pkg::CNT_ZERO;
    else if (hf_cnt < CNT_W_L'(iob_pkg::STABLE_CYC))
      hf_cnt <= hf_cnt + iob_pkg::CNT_ONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mf_ready_flag  <= 1'b0;
      hf_ready_flag  <= 1'b0;
      hf_locked_flag <= 1'b0;
      hf_stable_flag <= 1'b0;
    end else begin
      mf_ready_flag  <= mf_en
        && (mf_cnt >= CNT_W_L'(iob_pkg::START_CYC));
      hf_ready_flag  <= hf_en
        && (hf_cnt >= CNT_W_L'(iob_pkg::START_CYC));
      hf_locked_flag <= hf_en
        && (hf_cnt >= CNT_W_L'(iob_pkg::LOCK_CYC));
      hf_stable_flag <= hf_en
        && (hf_cnt >= CNT_W_L'(iob_pkg::STABLE_CYC));
    end
  end

  // requested source, forced low when not internal
  assign next_src = sel_internal ? src_of(internal_freq_select)
                                 : iob_pkg::IOB_SRC_LF;

  always_comb begin
    case (tgt_src)
      iob_pkg::IOB_SRC_HF: tgt_tick = hf_tick;
      iob_pkg::IOB_SRC_MF: tgt_tick = mf_tick;
      default:             tgt_tick = lf_tick;
    endcase
  end

  // glitch-free switch: wait ready, then count target edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state <= iob_pkg::IOB_SW_RUN;
      cur_src  <= iob_pkg::IOB_SRC_LF;
      tgt_src  <= iob_pkg::IOB_SRC_LF;
      sync_cnt <= 2'h0;
    end else begin
      case (sw_state)
        iob_pkg::IOB_SW_RUN: begin
          if (next_src != cur_src) begin
            tgt_src  <= next_src;
            sync_cnt <= 2'h0;
            sw_state <= iob_pkg::IOB_SW_WAIT;
          end
        end
        iob_pkg::IOB_SW_WAIT: begin
          if (next_src != tgt_src)
            sw_state <= iob_pkg::IOB_SW_RUN;
          else if ((tgt_src == iob_pkg::IOB_SRC_LF)
                   || (tgt_src == iob_pkg::IOB_SRC_MF && mf_ready_flag)
                   || (tgt_src == iob_pkg::IOB_SRC_HF && hf_ready_flag))
            sw_state <= iob_pkg::IOB_SW_SYNC;
        end
        iob_pkg::IOB_SW_SYNC: begin
          if (next_src != tgt_src)
            sw_state <= iob_pkg::IOB_SW_RUN;
          else if (tgt_tick) begin
            if (sync_cnt == iob_pkg::SYNC_EDGES - 2'h1) begin
              cur_src  <= tgt_src;
              sw_state <= iob_pkg::IOB_SW_RUN;
            end else begin
              sync_cnt <= sync_cnt + 2'h1;
            end
          end
        end
        default: sw_state <= iob_pkg::IOB_SW_RUN;
      endcase
    end
  end

  always_comb begin
    case (cur_src)
      iob_pkg::IOB_SRC_HF: post_tick = hf_tick;
      iob_pkg::IOB_SRC_MF: post_tick = mf_tick;
      default:             post_tick = lf_tick;
    endcase
  end

  // wrap after exactly 2^cur_div source ticks
  assign post_wrap = post_cnt == ((9'h001 << cur_div) - 9'h001);

  // postscaler: divisor latched only at a wrap to avoid runt periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= 9'h000;
      cur_div  <= 4'h0;
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= 1'b0;
      if (post_tick) begin
        if (post_wrap) begin
          post_cnt   <= 9'h000;
          cur_div    <= div_log2(internal_freq_select);
          sys_clk_en <= 1'b1;
        end else begin
          post_cnt <= post_cnt + 9'h001;
        end
      end
    end
  end

  assign active_source = cur_src;

endmodule : iob_internal_osc

// file: rtl/iob_pkg.sv
// constants for the internal oscillator block
package iob_pkg;
  // configuration and select encodings
  localparam logic [2:0] OSC_CFG_INTERNAL = 3'h4;
  localparam logic [3:0] FREQ_SEL_LF      = 4'h0;
  localparam logic [3:0] FREQ_SEL_HF_MIN  = 4'hA;
  localparam logic [3:0] FREQ_SEL_MF_MIN  = 4'h1;
  localparam logic [3:0] FREQ_SEL_MF_MAX  = 4'h9;
  localparam logic [5:0] TRIM_RESET       = 6'h00;
  // clock rates
  localparam int CLK_HZ      = 20000000;
  localparam int HF_HZ       = 16000000;
  localparam int MF_HZ       = 500000;
  localparam int LF_HZ       = 31000;
  localparam int PLL_MULT    = HF_HZ / MF_HZ;
  // settling times in microseconds
  localparam int START_US    = 5;
  localparam int LOCK_US     = 20;
  localparam int STABLE_US   = 50;
  localparam int START_CYC   = (START_US * CLK_HZ + 999999) / 1000000;
  localparam int LOCK_CYC    = (LOCK_US * CLK_HZ + 999999) / 1000000;
  localparam int STABLE_CYC  = (STABLE_US * CLK_HZ + 999999) / 1000000;
  localparam int CNT_W       = 11;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 11'h001;
  // clock switch sync length in target enables
  localparam logic [1:0] SYNC_EDGES = 2'h2;
  typedef enum logic [1:0] {
    IOB_SRC_LF = 2'b00,
    IOB_SRC_MF = 2'b01,
    IOB_SRC_HF = 2'b10
  } iob_src_t;
  typedef enum logic [1:0] {
    IOB_SW_RUN  = 2'b00,
    IOB_SW_WAIT = 2'b01,
    IOB_SW_SYNC = 2'b10
  } iob_sw_t;
endpackage : iob_pkg

// file: verification/iob_internal_osc_properties.sv
// checker for the internal oscillator block ports
`timescale 1ns/1ps
module iob_internal_osc_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // controls
  input wire logic [2:0] osc_config_select,
  input wire logic       clk_pin_output_enable,
  input wire logic [1:0] sys_clk_source_select,
  input wire logic [3:0] internal_freq_select,
  input wire logic       clock_output_pin_gpio_out,
  // outputs
  input wire logic       clock_output_pin,
  input wire logic       sys_clk_en,
  input wire logic       internal_osc_mode,
  input wire logic [1:0] active_source,
  input wire logic       hf_ready_flag,
  input wire logic       hf_locked_flag,
  input wire logic       hf_stable_flag,
  input wire logic       mf_ready_flag
);
  logic [1:0]  live_cnt;
  logic [10:0] hf_cnt;
  logic        live;
  logic        hf_en;
  logic        mf_en;
  assign live  = live_cnt == 2'h3;
  assign hf_en = internal_osc_mode && internal_freq_select >= 4'hA;
  assign mf_en = internal_osc_mode && internal_freq_select != 4'h0;
  // design reset lags the pin by its two sync flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) live_cnt <= 2'h0;
    else if (!live) live_cnt <= live_cnt + 2'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hf_cnt <= 11'h000;
    else if (!live || !hf_en) hf_cnt <= 11'h000;
    else if (hf_cnt != 11'h7FF) hf_cnt <= hf_cnt + 11'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_mode;
    internal_osc_mode == (sys_clk_source_select[1] ||
      osc_config_select == iob_pkg::OSC_CFG_INTERNAL);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_gpio;
    live && $past(live) && !$past(internal_osc_mode && clk_pin_output_enable)
      |-> clock_output_pin == $past(clock_output_pin_gpio_out);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pass");
  property p_hf_off;
    live && !hf_en |=> !hf_ready_flag && !hf_locked_flag && !hf_stable_flag;
  endproperty
  a_hf_off: assert property (p_hf_off) else $error("hf flags");
  property p_mf_off;
    live && !mf_en |=> !mf_ready_flag;
  endproperty
  a_mf_off: assert property (p_mf_off) else $error("mf flag");
  property p_order;
    hf_stable_flag |-> hf_locked_flag && hf_ready_flag;
  endproperty
  a_order: assert property (p_order) else $error("flag order");
  property p_hf_early;
    hf_cnt < 11'd99 |-> !hf_ready_flag;
  endproperty
  a_hf_early: assert property (p_hf_early) else $error("early rdy");
  property p_hf_lock;
    hf_cnt == 11'd405 |-> hf_locked_flag && !hf_stable_flag;
  endproperty
  a_hf_lock: assert property (p_hf_lock) else $error("lock time");
  property p_src;
    live && $changed(active_source) |->
      (active_source != 2'h2 || $past(hf_ready_flag)) &&
      (active_source != 2'h1 || $past(mf_ready_flag));
  endproperty
  a_src: assert property (p_src) else $error("early switch");
  property p_en_gap;
    sys_clk_en && active_source == 2'h1 |=> !sys_clk_en [*8];
  endproperty
  a_en_gap: assert property (p_en_gap) else $error("mf rate");
endmodule : iob_internal_osc_checker
bind iob_internal_osc iob_internal_osc_checker i_iob_internal_osc_checker (
  .clk, .arst_n, .osc_config_select, .clk_pin_output_enable,
  .sys_clk_source_select, .internal_freq_select, .clock_output_pin_gpio_out,
  .clock_output_pin, .sys_clk_en, .internal_osc_mode, .active_source,
  .hf_ready_flag, .hf_locked_flag, .hf_stable_flag, .mf_ready_flag);

// file: verification/iob_internal_osc_tb.sv
// self-checking bench for the internal oscillator block
`timescale 1ns/1ps
module iob_internal_osc_tb;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] osc_config_select = 3'h0;
  logic       clk_pin_output_enable = 1'b0;
  logic [1:0] sys_clk_source_select = 2'h0;
  logic [3:0] internal_freq_select = 4'h0;
  logic [5:0] osc_trim_reg = 6'h00;
  logic       clock_input_pin = 1'b0;
  logic       clock_output_pin_gpio_out = 1'b0;
  logic       clock_output_pin_gpio_oe = 1'b0;
  logic       clock_input_pin_gpio_in, clock_output_pin, clock_output_pin_oe;
  logic       sys_clk_en, internal_osc_mode, lf_tick;
  logic       hf_ready_flag, hf_locked_flag, hf_stable_flag, mf_ready_flag;
  logic [1:0] active_source;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cnt;
  iob_internal_osc i_iob_internal_osc (.*);
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic setup(input logic [2:0] c, input logic [1:0] s,
                       input logic [3:0] f);
    @(posedge clk);
    osc_config_select <= c;
    sys_clk_source_select <= s;
    internal_freq_select <= f;
  endtask : setup
  // bounded wait, the switch length depends on the target rate
  task automatic wait_src(input logic [1:0] s, input int lim);
    cnt = 0;
    while (active_source !== s && cnt < lim) begin
      tick(1);
      cnt++;
    end
    total_checks++;
    if (active_source !== s) begin
      n_mismatch++;
      $display("CHECK FAILED active_source exp %h got %h", s, active_source);
    end
  endtask : wait_src
  // counts clock enables, then checks against a +-2 window
  task automatic rate(input int n, input int exp);
    cnt = 0;
    repeat (n) begin
      tick(1);
      if (sys_clk_en === 1'b1) cnt++;
    end
    chk("sys_clk_en rate", 1'b1, cnt >= exp - 2 && cnt <= exp + 2);
  endtask : rate
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #(20000 * 50);
    n_mismatch++;
    finish_test();
  end
  initial begin
    tick(5);
    chk("hf_ready_flag", 1'b0, hf_ready_flag);
    wait_src(2'h0, 1);
    @(posedge clk);
    arst_n <= 1'b1;
    tick(3);
    for (int i = 0; i < 32; i++) begin
      setup(i[4:2], i[1:0], 4'h0);
      tick(1);
      chk("internal_osc_mode", i[1] || i[4:2] == 4, internal_osc_mode);
    end
    $display("mode test done");
    setup(3'h0, 2'h0, 4'h0);
    clock_output_pin_gpio_out <= 1'b1;
    clock_output_pin_gpio_oe <= 1'b1;
    clock_input_pin <= 1'b1;
    tick(6);
    chk("clock_output_pin", 1'b1, clock_output_pin);
    chk("clock_output_pin_oe", 1'b1, clock_output_pin_oe);
    chk("clock_input_pin_gpio_in", 1'b1, clock_input_pin_gpio_in);
    $display("pin test done");
    setup(3'h4, 2'h0, 4'hF);
    tick(95);
    chk("hf_ready_flag", 1'b0, hf_ready_flag);
    tick(15);
    chk("hf_ready_flag", 1'b1, hf_ready_flag);
    chk("mf_ready_flag", 1'b1, mf_ready_flag);
    tick(300);
    chk("hf_locked_flag", 1'b1, hf_locked_flag);
    chk("hf_stable_flag", 1'b0, hf_stable_flag);
    tick(600);
    chk("hf_stable_flag", 1'b1, hf_stable_flag);
    wait_src(2'h2, 200);
    for (int f = 15; f > 11; f--) begin
      setup(3'h4, 2'h0, f[3:0]);
      tick(20);
      rate(200, 160 >> (15 - f));
    end
    clk_pin_output_enable <= 1'b1;
    clock_output_pin_gpio_oe <= 1'b0;
    tick(3);
    chk("clock_output_pin_oe", 1'b1, clock_output_pin_oe);
    $display("high test done");
    setup(3'h4, 2'h0, 4'h9);
    tick(2);
    chk("hf_ready_flag", 1'b0, hf_ready_flag);
    chk("mf_ready_flag", 1'b1, mf_ready_flag);
    wait_src(2'h1, 400);
    for (int f = 9; f > 6; f--) begin
      setup(3'h4, 2'h0, f[3:0]);
      tick(200);
      rate(800, 20 >> (9 - f));
    end
    $display("medium test done");
    setup(3'h4, 2'h0, 4'h0);
    tick(2);
    chk("mf_ready_flag", 1'b0, mf_ready_flag);
    wait_src(2'h0, 3000);
    cnt = 0;
    repeat (2000) begin
      tick(1);
      if (lf_tick === 1'b1) cnt++;
    end
    chk("lf_tick rate", 1'b1, cnt >= 2 && cnt <= 4);
    $display("low test done");
    setup(3'h0, 2'h2, 4'hA);
    tick(110);
    chk("hf_ready_flag", 1'b1, hf_ready_flag);
    setup(3'h0, 2'h0, 4'hA);
    tick(2);
    chk("hf_ready_flag", 1'b0, hf_ready_flag);
    $display("run-time select test done");
    finish_test();
  end
endmodule : iob_internal_osc_tb
